// >>> irpc_control.sv
// Control state machine of a remote-controlled preamp: IR commands, knob, relays, display.
// Assumes a frame decoder upstream on core_clk and an AHB-Lite master with one slave.
// Summary of operation
// R1: Power-up ramp counts volume 10 to 30 by 2
// R2: Unsupported frame during ramp shows dashes
// R3: Programming exits after five idle seconds
// R4: Digit 9 during ramp enters slot 1
// R5: Digit 9 advances slot, wraps 9 to 1
// R6: Other key stores code, confirms or fails
// R7: Slots map to nine fixed functions
// R8: Highest-channel key sets input count
// R9: Learned device address gates all responses except digit 9, ramp dashes and programming entries
// R10: Unmatched frames dropped outside ramp and programming
// R11: Factory codes are RC5 television address
// R12: Power-down drops mains and all relays
// R13: Powered down ignores volume and mute
// R14: Ramp restores last channel and saved volume
// R15: Volume or channel command aborts ramp
// R16: Channel up/down wrap; digits select directly
// R17: Mute toggles; volume change ends mute
// R18: Delayed power command or channel powers up
// R19: Knob steps volume, clipped 0 to 64
// R20: Knob turn cancels mute
// R21: Click advances input, wraps 6 to 1
// R22: Five-second button hold powers down
// R23: Handshake idle and ack faults shown
// R24: Only timing-checked supported frames decoded
`timescale 1ns/100ps
`include "irpc_defines.svh"
module irpc_control #(
  parameter int RAMP_STEP_CYC = `IRPC_CLK_HZ / 1000 * `IRPC_RAMP_STEP_MS,
  parameter int PROG_IDLE_CYC = `IRPC_CLK_HZ / 1000 * `IRPC_PROG_IDLE_MS,
  parameter int HOLD_CYC      = `IRPC_CLK_HZ / 1000 * `IRPC_HOLD_MS,
  parameter int REPOWER_CYC   = `IRPC_CLK_HZ / 1000 * `IRPC_REPOWER_MS,
  parameter int ACK_WAIT_CYC  = `IRPC_CLK_HZ / 1000 * `IRPC_ACK_WAIT_MS
) (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 reset_n,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic [31:0]               hrdata,
  output logic                      hresp,
  // Decoded infrared frames
  input  wire irpc_pkg::irpc_frame_t ir_frame,
  // Front-panel knob pins
  input  wire logic                 knob_a,
  input  wire logic                 knob_b,
  input  wire logic                 knob_btn,
  // Relay board
  input  wire logic                 hs_line,
  input  wire logic                 hs_ack,
  output irpc_pkg::irpc_relay_t     relay,
  output logic                      relay_strobe,
  // Display
  output irpc_pkg::irpc_disp_t      display
);
  localparam int NPIN = 5;
  localparam logic [71:0] DEF_CODES = `IRPC_DEF_CODES;

  irpc_pkg::irpc_mode_t mode, next_mode;
  logic [6:0]  vol, next_vol, saved_vol, ramp_target, next_target;
  logic [2:0]  ch, next_ch;
  logic        muted, next_muted;
  logic [3:0]  slot, next_slot;
  logic [27:0] timer, next_timer;
  irpc_pkg::irpc_disp_t disp_sel;
  logic [2:0]  ctrl;
  logic        slot_we;

  // AHB-Lite: zero-wait slave, data phase decoded from registered address
  logic        ap_valid;
  logic        ap_write;
  logic [7:0]  ap_addr;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr  <= 8'h00;
    end else if (hready) begin
      ap_valid <= hsel & htrans[1];
      ap_write <= hwrite;
      ap_addr  <= haddr[7:0];
    end
  end
  wire wr_ctrl     = ap_valid & ap_write & (ap_addr == `IRPC_OFF_CTRL);
  wire rd_valid    = ap_valid & ~ap_write;
  wire restart_req = wr_ctrl & hwdata[`IRPC_CTRL_RESTART];
  wire idle_fault;
  wire ack_fault;
  wire [31:0] status_word = {6'h00, ack_fault, idle_fault, slot, 2'h0, mode, 3'h0, muted, 1'h0, ch, 1'h0, vol};
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = !rd_valid                      ? 32'h0000_0000 :
                     (ap_addr == `IRPC_OFF_CTRL)    ? {30'h0, ctrl[1:0]} :
                     (ap_addr == `IRPC_OFF_STATUS)  ? status_word :
                     (ap_addr == `IRPC_OFF_DISPLAY) ? {22'h0, display} : 32'h0000_0000;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) ctrl <= `IRPC_CTRL_RESET;
    else if (wr_ctrl) ctrl <= {1'b0, hwdata[1:0]};
  end

  // Pin synchronisers: a change counts once stages two and three agree
  wire [NPIN-1:0] pin_raw = {hs_ack, hs_line, knob_btn, knob_b, knob_a};
  logic [NPIN-1:0] sync1, sync2, sync3, pin_f;
  genvar gp;
  generate
    for (gp = 0; gp < NPIN; gp++) begin : g_sync
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          sync1[gp] <= 1'b0;
          sync2[gp] <= 1'b0;
          sync3[gp] <= 1'b0;
          pin_f[gp] <= 1'b0;
        end else begin
          sync1[gp] <= pin_raw[gp];
          sync2[gp] <= sync1[gp];
          sync3[gp] <= sync2[gp];
          if (sync2[gp] == sync3[gp]) pin_f[gp] <= sync3[gp];
        end
      end
    end
  endgenerate
  logic [NPIN-1:0] pin_d;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) pin_d <= '0;
    else pin_d <= pin_f;
  end
  wire knob_on   = ctrl[`IRPC_CTRL_KNOB];
  wire a_rise    = pin_f[0] & ~pin_d[0];
  wire knob_up   = knob_on & a_rise & ~pin_f[1];
  wire knob_dn   = knob_on & a_rise & pin_f[1];
  wire btn_rel   = ~pin_f[2] & pin_d[2];
  wire ack_rise  = pin_f[4] & ~pin_d[4];

  // Button hold: long press powers down once, release after it is no click
  logic [27:0] hold_cnt;
  logic        held;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_cnt <= 28'h0;
      held     <= 1'b0;
    end else if (!pin_f[2] || !knob_on) begin
      hold_cnt <= 28'h0;
      held     <= held & pin_f[2] & knob_on;
    end else if (hold_cnt == 28'(HOLD_CYC - 1)) begin
      hold_cnt <= 28'h0;
      held     <= 1'b1;
    end else if (!held) begin
      hold_cnt <= hold_cnt + 28'h1;
    end
  end
  wire hold_pwr = knob_on & pin_f[2] & ~held & (hold_cnt == 28'(HOLD_CYC - 1)); // R22
  wire click    = knob_on & btn_rel & ~held;

  // Learned slots: code, address and format per function
  logic [7:0]          slot_code [9];
  logic [7:0]          slot_addr [9];
  irpc_pkg::irpc_fmt_t slot_fmt  [9];
  logic [8:0]          hit;
  wire frame_ok = ir_frame.valid & ir_frame.timing_ok & (ir_frame.fmt != irpc_pkg::IRPC_FMT_OTHER); // R24
  genvar gs;
  generate
    for (gs = 0; gs < 9; gs++) begin : g_slot
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          slot_code[gs] <= DEF_CODES[gs*8 +: 8]; // R11
          slot_addr[gs] <= `IRPC_DEF_ADDR;
          slot_fmt[gs]  <= irpc_pkg::IRPC_FMT_RC5;
        end else if (slot_we && slot == 4'(gs + 1)) begin
          slot_code[gs] <= ir_frame.cmd; // R6
          slot_addr[gs] <= ir_frame.addr; // R9
          slot_fmt[gs]  <= ir_frame.fmt;
        end
      end
      assign hit[gs] = frame_ok && ir_frame.fmt == slot_fmt[gs] && ir_frame.addr == slot_addr[gs]
                       && ir_frame.cmd == slot_code[gs]; // R9 R10
    end
  endgenerate

  // Numeric keys: offset from the first-channel code, limited by the highest-channel code
  wire [7:0] ch_span   = slot_code[6] - slot_code[5];
  wire [2:0] max_ch    = (ch_span >= 8'h06) ? `IRPC_CH_LAST : ch_span[2:0] + 3'h1; // R8
  wire [7:0] digit_off = ir_frame.cmd - slot_code[5];
  wire digit_hit = frame_ok && ir_frame.fmt == slot_fmt[5] && ir_frame.addr == slot_addr[5]
                   && digit_off < {5'h00, max_ch}; // R16
  wire is_nine   = frame_ok && ir_frame.cmd == ((ir_frame.fmt == irpc_pkg::IRPC_FMT_SIRC) ?
                   `IRPC_SIRC_DIGIT9 : `IRPC_RC_DIGIT9); // R4
  wire unsupported = ir_frame.valid & ~frame_ok;
  wire vol_up  = hit[0] | knob_up; // R19
  wire vol_dn  = hit[1] | knob_dn;
  wire ch_ev   = hit[3] | hit[4] | digit_hit;
  wire [2:0] ch_up_w = (ch >= max_ch) ? `IRPC_CH_FIRST : ch + 3'h1;
  wire [2:0] ch_dn_w = (ch <= `IRPC_CH_FIRST) ? max_ch : ch - 3'h1;
  wire [2:0] ch_cmd  = digit_hit ? digit_off[2:0] + 3'h1 : hit[3] ? ch_up_w : ch_dn_w; // R16
  wire [2:0] ch_clk  = (ch >= `IRPC_CH_LAST) ? `IRPC_CH_FIRST : ch + 3'h1; // R21
  wire [6:0] vol_inc = (vol >= `IRPC_VOL_MAX) ? `IRPC_VOL_MAX : vol + 7'h01;
  wire [6:0] vol_dec = (vol == `IRPC_VOL_MIN) ? `IRPC_VOL_MIN : vol - 7'h01;
  wire [6:0] ramp_nv = vol + `IRPC_RAMP_INC;
  wire [6:0] ramp_lo = (saved_vol >= `IRPC_RAMP_SPAN) ? saved_vol - `IRPC_RAMP_SPAN : `IRPC_VOL_MIN;
  wire step_due  = timer == 28'(RAMP_STEP_CYC - 1);
  wire prog_idle = timer == 28'(PROG_IDLE_CYC - 1);
  wire repower   = timer >= 28'(REPOWER_CYC - 1);
  irpc_pkg::irpc_disp_t show_vol, show_ch;
  assign show_vol = '{kind: irpc_pkg::IRPC_D_VOLUME, value: next_vol};
  assign show_ch  = '{kind: irpc_pkg::IRPC_D_CHANNEL, value: {4'h0, next_ch}};

  always_comb begin
    next_mode   = mode;
    next_vol    = vol;
    next_ch     = ch;
    next_muted  = muted;
    next_slot   = slot;
    next_target = ramp_target;
    next_timer  = (timer == 28'hFFF_FFFF) ? timer : timer + 28'h1;
    disp_sel    = display;
    slot_we     = 1'b0;
    if (restart_req) begin
      next_mode   = irpc_pkg::IRPC_M_RAMP; // R14
      next_vol    = ramp_lo;
      next_target = saved_vol;
      next_muted  = 1'b0;
      next_timer  = 28'h0;
      disp_sel    = '{kind: irpc_pkg::IRPC_D_VOLUME, value: ramp_lo};
    end else begin
      case (mode)
        irpc_pkg::IRPC_M_PROG: begin
          if (ir_frame.valid) begin
            next_timer = 28'h0;
            if (is_nine) begin
              next_slot = (slot >= `IRPC_SLOT_LAST) ? `IRPC_SLOT_FIRST : slot + 4'h1; // R5
              disp_sel  = '{kind: irpc_pkg::IRPC_D_PROG_SLOT, value: {3'h0, next_slot}};
            end else if (frame_ok) begin
              slot_we  = 1'b1; // R6 R7
              disp_sel = '{kind: irpc_pkg::IRPC_D_CONFIRM, value: {3'h0, slot}};
            end else begin
              disp_sel = '{kind: irpc_pkg::IRPC_D_PROG_FAIL, value: 7'h00}; // R6
            end
          end else if (prog_idle) begin
            next_mode = irpc_pkg::IRPC_M_NORMAL; // R3
            disp_sel  = show_ch;
          end
        end
        irpc_pkg::IRPC_M_DOWN: begin
          if (ch_ev || click || (hit[7] && repower)) begin
            next_mode = irpc_pkg::IRPC_M_NORMAL; // R18 R13
            if (ch_ev) next_ch = ch_cmd;
            disp_sel  = show_ch;
          end
        end
        default: begin
          if (mode == irpc_pkg::IRPC_M_RAMP && unsupported) begin
            disp_sel = '{kind: irpc_pkg::IRPC_D_DASHES, value: 7'h00}; // R2
          end else if (mode == irpc_pkg::IRPC_M_RAMP && is_nine) begin
            next_mode  = irpc_pkg::IRPC_M_PROG; // R4
            next_slot  = `IRPC_SLOT_FIRST;
            next_timer = 28'h0;
            disp_sel   = '{kind: irpc_pkg::IRPC_D_PROG_SLOT, value: {3'h0, `IRPC_SLOT_FIRST}};
          end else if (hit[7] || hold_pwr) begin
            next_mode  = irpc_pkg::IRPC_M_DOWN; // R12
            next_timer = 28'h0;
          end else if (vol_up || vol_dn) begin
            next_mode  = irpc_pkg::IRPC_M_NORMAL; // R15
            next_muted = 1'b0; // R17 R20
            next_vol   = vol_up ? vol_inc : vol_dec;
            disp_sel   = show_vol;
          end else if (ch_ev || click) begin
            next_mode = irpc_pkg::IRPC_M_NORMAL; // R15
            next_ch   = ch_ev ? ch_cmd : ch_clk;
            disp_sel  = show_ch;
          end else if (hit[2]) begin
            next_muted = ~muted; // R17
            disp_sel   = show_vol;
          end else if (hit[8]) begin
            disp_sel = show_ch;
          end else if (mode == irpc_pkg::IRPC_M_RAMP && step_due) begin
            next_timer = 28'h0; // R1 R14
            next_vol   = (ramp_nv >= ramp_target) ? ramp_target : ramp_nv;
            if (ramp_nv >= ramp_target) next_mode = irpc_pkg::IRPC_M_NORMAL;
            disp_sel   = show_vol;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode        <= irpc_pkg::IRPC_M_RAMP;
      vol         <= `IRPC_VOL_DEFAULT - `IRPC_RAMP_SPAN;
      saved_vol   <= `IRPC_VOL_DEFAULT;
      ramp_target <= `IRPC_VOL_DEFAULT;
      ch          <= `IRPC_CH_FIRST;
      muted       <= 1'b0;
      slot        <= `IRPC_SLOT_FIRST;
      timer       <= 28'h0;
    end else begin
      mode        <= next_mode;
      vol         <= next_vol;
      ramp_target <= next_target;
      ch          <= next_ch;
      muted       <= next_muted;
      slot        <= next_slot;
      timer       <= next_timer;
      if (next_mode == irpc_pkg::IRPC_M_DOWN && mode != irpc_pkg::IRPC_M_DOWN) saved_vol <= vol;
    end
  end

  // Relay board: one command in flight, ack awaited before the next
  irpc_pkg::irpc_relay_t relay_want;
  wire powered = (mode != irpc_pkg::IRPC_M_DOWN);
  assign relay_want.level     = (powered && !muted) ? vol : 7'h00; // R12 R17
  assign relay_want.input_sel = powered ? 6'(6'h01 << (ch - 3'h1)) : 6'h00;
  assign relay_want.mains     = powered & ctrl[`IRPC_CTRL_MAINS];
  logic        pending;
  logic        ack_bad;
  logic [27:0] ack_cnt;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      relay        <= '0;
      relay_strobe <= 1'b0;
      pending      <= 1'b0;
      ack_bad      <= 1'b0;
      ack_cnt      <= 28'h0;
    end else begin
      relay_strobe <= 1'b0;
      if (pending) begin
        ack_cnt <= ack_cnt + 28'h1;
        if (ack_rise) begin
          pending <= 1'b0;
          ack_bad <= 1'b0;
        end else if (ack_cnt == 28'(ACK_WAIT_CYC - 1)) begin
          pending <= 1'b0;
          ack_bad <= 1'b1; // R23
        end
      end else if (relay_want != relay) begin
        relay        <= relay_want;
        relay_strobe <= 1'b1;
        pending      <= 1'b1;
        ack_cnt      <= 28'h0;
      end
    end
  end
  assign idle_fault = ~pending & pin_f[3]; // R23
  assign ack_fault  = ack_bad;

  // Faults override whatever the control logic wants shown
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) display <= '{kind: irpc_pkg::IRPC_D_VOLUME, value: `IRPC_VOL_DEFAULT - `IRPC_RAMP_SPAN};
    else if (idle_fault) display <= '{kind: irpc_pkg::IRPC_D_IDLE_FAULT, value: 7'h00}; // R23
    else if (ack_fault) display <= '{kind: irpc_pkg::IRPC_D_ACK_FAULT, value: 7'h00};
    else display <= disp_sel;
  end

  a_vol_limit: assert property (@(posedge core_clk) disable iff (!reset_n) vol <= `IRPC_VOL_MAX) // R19
    else $error("volume above limit");
  a_ramp_step: assert property (@(posedge core_clk) disable iff (!reset_n)
    mode == irpc_pkg::IRPC_M_RAMP && step_due && !ir_frame.valid && !knob_up && !knob_dn && !click
    && !hold_pwr && !restart_req && vol + 7'h02 < ramp_target |=> vol == $past(vol) + 7'h02) // R1
    else $error("ramp did not step by two");
  a_slot_wrap: assert property (@(posedge core_clk) disable iff (!reset_n)
    mode == irpc_pkg::IRPC_M_PROG && is_nine && slot == 4'h9 && !restart_req |=> slot == 4'h1) // R5
    else $error("slot did not wrap to one");
  a_prog_exit: assert property (@(posedge core_clk) disable iff (!reset_n)
    mode == irpc_pkg::IRPC_M_PROG && prog_idle && !ir_frame.valid && !restart_req && !idle_fault && !ack_fault
    |=> mode == irpc_pkg::IRPC_M_NORMAL && display.kind == irpc_pkg::IRPC_D_CHANNEL) // R3
    else $error("programming mode did not time out");
  a_down_vol_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    mode == irpc_pkg::IRPC_M_DOWN && !restart_req |=> $stable(vol) && $stable(muted)) // R13
    else $error("volume changed while powered down");
  a_down_relays: assert property (@(posedge core_clk) disable iff (!reset_n)
    mode == irpc_pkg::IRPC_M_DOWN && !pending |=> relay == '0) // R12
    else $error("mains relay held in power down");
  a_unmute_vol: assert property (@(posedge core_clk) disable iff (!reset_n)
    muted && mode == irpc_pkg::IRPC_M_NORMAL && (knob_up || knob_dn) && !ir_frame.valid && !restart_req
    && !hold_pwr |=> !muted) // R20
    else $error("knob turn left mute on");
  a_dash_show: assert property (@(posedge core_clk) disable iff (!reset_n)
    mode == irpc_pkg::IRPC_M_RAMP && unsupported && !restart_req && !idle_fault && !ack_fault
    |=> display.kind == irpc_pkg::IRPC_D_DASHES) // R2
    else $error("unsupported frame not shown as dashes");
  a_hold_down: assert property (@(posedge core_clk) disable iff (!reset_n)
    hold_pwr && mode == irpc_pkg::IRPC_M_NORMAL && !ir_frame.valid && !restart_req
    |=> mode == irpc_pkg::IRPC_M_DOWN) // R22
    else $error("long press did not power down");
  a_ch_range: assert property (@(posedge core_clk) disable iff (!reset_n)
    ch >= 3'h1 && ch <= 3'h6) // R16
    else $error("channel out of range");
endmodule : irpc_control

// >>> irpc_defines.svh
// Constants for the remote-controlled preamp control block.
// Assumes inclusion by the control module only.
`ifndef IRPC_DEFINES_SVH
`define IRPC_DEFINES_SVH
// Register byte offsets
`define IRPC_OFF_CTRL      8'h00
`define IRPC_OFF_STATUS    8'h04
`define IRPC_OFF_DISPLAY   8'h08
// Control register: bit0 knob enable, bit1 mains relay fitted, bit2 restart ramp
`define IRPC_CTRL_RESET    3'h3
`define IRPC_CTRL_KNOB     0
`define IRPC_CTRL_MAINS    1
`define IRPC_CTRL_RESTART  2
// Clock and times
`define IRPC_CLK_HZ        25000000
`define IRPC_RAMP_STEP_MS  1000
`define IRPC_PROG_IDLE_MS  5000
`define IRPC_HOLD_MS       5000
`define IRPC_REPOWER_MS    1000
`define IRPC_ACK_WAIT_MS   1
// Volume and channel
`define IRPC_VOL_MAX       7'h40
`define IRPC_VOL_MIN       7'h00
`define IRPC_VOL_DEFAULT   7'h1E
`define IRPC_RAMP_SPAN     7'h14
`define IRPC_RAMP_INC      7'h02
`define IRPC_CH_FIRST      3'h1
`define IRPC_CH_LAST       3'h6
`define IRPC_SLOT_FIRST    4'h1
`define IRPC_SLOT_LAST     4'h9
// Remote key codes
`define IRPC_RC_DIGIT9     8'h09
`define IRPC_SIRC_DIGIT9   8'h08
`define IRPC_DEF_ADDR      8'h00
// Factory codes, slot 1 in the low byte
`define IRPC_DEF_CODES     72'h0F0C06012120_0D1110
`endif

// >>> irpc_pkg.sv
// Types shared by the preamp control block.
// Assumes irpc_defines.svh is on the include path.
package irpc_pkg;
  typedef enum logic [1:0] {
    IRPC_FMT_RC5   = 2'h0,
    IRPC_FMT_RC6   = 2'h1,
    IRPC_FMT_SIRC  = 2'h2,
    IRPC_FMT_OTHER = 2'h3
  } irpc_fmt_t;
  typedef enum logic [1:0] {
    IRPC_M_RAMP   = 2'h0,
    IRPC_M_NORMAL = 2'h1,
    IRPC_M_PROG   = 2'h3,
    IRPC_M_DOWN   = 2'h2
  } irpc_mode_t;
  typedef enum logic [2:0] {
    IRPC_D_VOLUME       = 3'h0,
    IRPC_D_CHANNEL      = 3'h1,
    IRPC_D_PROG_SLOT    = 3'h2,
    IRPC_D_PROG_FAIL    = 3'h3,
    IRPC_D_CONFIRM      = 3'h4,
    IRPC_D_DASHES       = 3'h5,
    IRPC_D_IDLE_FAULT   = 3'h6,
    IRPC_D_ACK_FAULT    = 3'h7
  } irpc_disp_kind_t;
  typedef struct packed {
    logic      valid;
    logic      timing_ok;
    irpc_fmt_t fmt;
    logic [7:0] addr;
    logic [7:0] cmd;
  } irpc_frame_t;
  typedef struct packed {
    irpc_disp_kind_t kind;
    logic [6:0]      value;
  } irpc_disp_t;
  typedef struct packed {
    logic [6:0] level;
    logic [5:0] input_sel;
    logic       mains;
  } irpc_relay_t;
endpackage : irpc_pkg

// >>> irpc_relay_board.sv
// Relay board model: acknowledges each relay update after a short delay.
// Assumes relay_strobe is a one-cycle pulse on core_clk.
`timescale 1ns/100ps
module irpc_relay_board (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // From the control block
  input  wire logic relay_strobe,
  // Scenario control: withhold acknowledges
  input  wire logic ack_off,
  // To the control block
  output logic      hs_line,
  output logic      hs_ack
);
  logic [2:0] dly;
  // Board pulls the handshake line low whenever idle
  assign hs_line = 1'b0;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dly    <= 3'h0;
      hs_ack <= 1'b0;
    end else begin
      dly    <= {dly[1:0], relay_strobe & ~ack_off};
      hs_ack <= |dly;
    end
  end
endmodule : irpc_relay_board

// >>> irpc_tb.sv
// Self-checking bench for the preamp control block.
// Assumes shortened timing parameters and the relay board model.
`timescale 1ns/100ps
module testbench;
  logic                  core_clk, reset_n, hsel, hwrite, knob_a, knob_b, knob_btn, ack_off;
  logic                  hreadyout, hresp, relay_strobe, hs_line, hs_ack;
  logic [1:0]            htrans;
  logic [2:0]            hsize;
  logic [31:0]           haddr, hwdata, hrdata, d;
  logic [6:0]            v;
  irpc_pkg::irpc_frame_t fr;
  irpc_pkg::irpc_relay_t relay;
  irpc_pkg::irpc_disp_t  display;
  int                    n_mismatch, n_checks, cyc;
  irpc_control #(.RAMP_STEP_CYC(20), .PROG_IDLE_CYC(100), .HOLD_CYC(50), .REPOWER_CYC(10), .ACK_WAIT_CYC(30)) i_dut (
    .core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .ir_frame(fr), .knob_a(knob_a), .knob_b(knob_b), .knob_btn(knob_btn), .hs_line(hs_line), .hs_ack(hs_ack),
    .relay(relay), .relay_strobe(relay_strobe), .display(display));
  irpc_relay_board i_board (.core_clk(core_clk), .reset_n(reset_n), .relay_strobe(relay_strobe),
    .ack_off(ack_off), .hs_line(hs_line), .hs_ack(hs_ack));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc   <= cyc + 1;
    if (cyc == 6000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_disp(input irpc_pkg::irpc_disp_kind_t k, input logic [6:0] val);
    n_checks++;
    if (display !== {k, val}) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, display, {k, val});
    end
  endtask : chk_disp
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge core_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask : ahb
  task automatic ir(input irpc_pkg::irpc_fmt_t f, input logic ok, input logic [7:0] a, input logic [7:0] c);
    @(posedge core_clk);
    fr <= '{1'b1, ok, f, a, c};
    @(posedge core_clk);
    fr.valid <= 1'b0;
    #1;
  endtask : ir
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : wait_cyc
  task automatic test_ramp;
    wait_cyc(30);
    chk_disp(irpc_pkg::IRPC_D_VOLUME, 7'h0C);
    ir(irpc_pkg::IRPC_FMT_OTHER, 1'b1, 8'h00, 8'h10);
    chk_disp(irpc_pkg::IRPC_D_DASHES, 7'h00);
    $display("test_ramp done");
  endtask : test_ramp
  task automatic test_prog;
    ir(irpc_pkg::IRPC_FMT_SIRC, 1'b1, 8'h5A, 8'h08);
    chk_disp(irpc_pkg::IRPC_D_PROG_SLOT, 7'h01);
    for (int s = 2; s <= 10; s++) begin
      ir(irpc_pkg::IRPC_FMT_RC6, 1'b1, 8'h00, 8'h09);
      chk_disp(irpc_pkg::IRPC_D_PROG_SLOT, (s == 10) ? 7'h01 : 7'(s));
    end
    ir(irpc_pkg::IRPC_FMT_RC5, 1'b1, 8'h00, 8'h10);
    chk_disp(irpc_pkg::IRPC_D_CONFIRM, 7'h01);
    ir(irpc_pkg::IRPC_FMT_RC5, 1'b0, 8'h00, 8'h22);
    chk_disp(irpc_pkg::IRPC_D_PROG_FAIL, 7'h00);
    wait_cyc(250);
    chk_disp(irpc_pkg::IRPC_D_CHANNEL, 7'h01);
    ahb(1'b0, 32'h0000_0004, 32'h0, d);
    chk_word(d[17:16], 32'h1);
    $display("test_prog done");
  endtask : test_prog
  task automatic test_volume;
    ahb(1'b0, 32'h0000_0004, 32'h0, d);
    v = 7'h0C;
    chk_word(d[6:0], 32'h0C);
    ir(irpc_pkg::IRPC_FMT_RC5, 1'b1, 8'h00, 8'h10);
    chk_disp(irpc_pkg::IRPC_D_VOLUME, v + 7'h01);
    ir(irpc_pkg::IRPC_FMT_RC5, 1'b1, 8'h33, 8'h10);
    chk_disp(irpc_pkg::IRPC_D_VOLUME, v + 7'h01);
    ir(irpc_pkg::IRPC_FMT_RC5, 1'b1, 8'h00, 8'h0D);
    wait_cyc(12);
    chk_word(relay.level, 32'h0);
    ir(irpc_pkg::IRPC_FMT_RC5, 1'b1, 8'h00, 8'h11);
    wait_cyc(12);
    chk_word(relay.level, v);
    ir(irpc_pkg::IRPC_FMT_RC5, 1'b1, 8'h00, 8'h21);
    chk_disp(irpc_pkg::IRPC_D_CHANNEL, 7'h06);
    ir(irpc_pkg::IRPC_FMT_RC5, 1'b1, 8'h00, 8'h01);
    chk_disp(irpc_pkg::IRPC_D_CHANNEL, 7'h01);
    ir(irpc_pkg::IRPC_FMT_RC5, 1'b1, 8'h00, 8'h0D);
    @(posedge core_clk) knob_a <= 1'b1;
    wait_cyc(10);
    @(posedge core_clk) knob_a <= 1'b0;
    wait_cyc(10);
    ahb(1'b0, 32'h0000_0004, 32'h0, d);
    chk_word(d[6:0], v + 7'h01);
    chk_word(d[12], 32'h0);
    @(posedge core_clk) knob_btn <= 1'b1;
    wait_cyc(70);
    ahb(1'b0, 32'h0000_0004, 32'h0, d);
    chk_word(d[17:16], 32'h2);
    @(posedge core_clk) knob_btn <= 1'b0;
    wait_cyc(10);
    for (int k = 2; k <= 3; k++) begin
      @(posedge core_clk) knob_btn <= 1'b1;
      wait_cyc(10);
      @(posedge core_clk) knob_btn <= 1'b0;
      wait_cyc(10);
      chk_disp(irpc_pkg::IRPC_D_CHANNEL, (k == 2) ? 7'h01 : 7'h02);
    end
    $display("test_volume done");
  endtask : test_volume
  task automatic test_power;
    ir(irpc_pkg::IRPC_FMT_RC5, 1'b1, 8'h00, 8'h0C);
    wait_cyc(12);
    chk_word(relay, 32'h0);
    ir(irpc_pkg::IRPC_FMT_RC5, 1'b1, 8'h00, 8'h10);
    wait_cyc(2);
    chk_word(relay, 32'h0);
    wait_cyc(12);
    ir(irpc_pkg::IRPC_FMT_RC5, 1'b1, 8'h00, 8'h0C);
    wait_cyc(2);
    chk_word(relay.mains, 32'h1);
    ack_off <= 1'b1;
    ir(irpc_pkg::IRPC_FMT_RC5, 1'b1, 8'h00, 8'h10);
    wait_cyc(45);
    chk_word(display.kind, irpc_pkg::IRPC_D_ACK_FAULT);
    ack_off <= 1'b0;
    ahb(1'b1, 32'h0000_0000, 32'h0000_0007, d);
    ahb(1'b0, 32'h0000_0004, 32'h0, d);
    chk_word(d[17:16], 32'h0);
    chk_word(d[6:0], 32'h0);
    ir(irpc_pkg::IRPC_FMT_RC5, 1'b1, 8'h00, 8'h10);
    ahb(1'b0, 32'h0000_0004, 32'h0, d);
    chk_word(d[17:16], 32'h1);
    chk_word(d[6:0], 32'h1);
    $display("test_power done");
  endtask : test_power
  initial begin
    reset_n = 1'b0;
    {hsel, hwrite, knob_a, knob_b, knob_btn, ack_off} = 6'h00;
    {htrans, hsize, haddr, hwdata} = {2'h0, 3'h2, 32'h0, 32'h0};
    fr = '0;
    n_mismatch = 0;
    n_checks = 0;
    cyc = 0;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    test_ramp();
    test_prog();
    test_volume();
    test_power();
    stop_test();
  end
endmodule : testbench
